// [asuw_params.svh]
// register offsets, field positions, reset values and timing counts of the serial transceiver
// assumes a 20 MHz system clock and 9-bit register addresses
`ifndef ASUW_PARAMS_SVH
`define ASUW_PARAMS_SVH

// register offsets
`define ASUW_ADR_CTRL    9'h120
`define ASUW_ADR_IRQCLK  9'h122
`define ASUW_ADR_RXBUF   9'h124
`define ASUW_ADR_TXBUF   9'h126
`define ASUW_ADR_RXCTL   9'h128
`define ASUW_ADR_R3      9'h18A
`define ASUW_ADR_T3      9'h18C
`define ASUW_ADR_DIVSEL  9'h18E

// serial_ctrl_status fields
`define ASUW_CTRL_TXRDY  0
`define ASUW_CTRL_RXRDY  1
`define ASUW_CTRL_XBIT9  2
`define ASUW_CTRL_NINE   3

// rx_ctrl_status fields
`define ASUW_RXC_BIT9    0
`define ASUW_RXC_WAKE    1
`define ASUW_RXC_FERR    2
`define ASUW_RXC_OVERR   3

// irq_clock_select fields
`define ASUW_IC_TXIE     0
`define ASUW_IC_RXIE     1
`define ASUW_IC_RXEXT    2
`define ASUW_IC_TXEXT    3
`define ASUW_IC_STOP2    4

// reset values
`define ASUW_RST_CTRL    4'h0
`define ASUW_RST_IRQCLK  5'h00
`define ASUW_RST_DIVSEL  4'hF
`define ASUW_RST_T3      16'hFFFF

// timing
`define ASUW_CLK_HZ      20000000
`define ASUW_TOP_HZ      131072
`define ASUW_PRE_CYC     (`ASUW_CLK_HZ / `ASUW_TOP_HZ)
`define ASUW_OVS_LAST    4'hF
`define ASUW_OVS_MID     4'h7

`endif

// [asuw_pkg.sv]
// types shared by the serial transceiver modules
// assumes nothing beyond the params header
package asuw_pkg;

  typedef enum logic [1:0] {
    ASUW_IDLE,
    ASUW_START,
    ASUW_DATA,
    ASUW_STOP
  } asuw_state_t;

  typedef struct packed {
    logic       nine;
    logic [7:0] data;
  } asuw_word_t;

  typedef struct packed {
    logic       done;
    logic       ferr;
    asuw_word_t word;
  } asuw_rx_res_t;

endpackage

// [asuw_baud.sv]
// internal rate source: binary-step divider or timer three underflow
// assumes the 20 MHz system clock; one tick per 16x sample period
`timescale 1ns/1ps
`include "asuw_params.svh"
module asuw_baud import asuw_pkg::*; #(
  parameter int unsigned PRE = `ASUW_PRE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // configuration
  input  wire logic [3:0]  sel,
  input  wire logic        t3_wr,
  input  wire logic        r3_wr,
  input  wire logic [15:0] wdata,
  // state and tick
  output logic      [15:0] t3_q,
  output logic      [15:0] r3_q,
  output logic             tick
);
  logic [7:0]  pre_q;
  logic        pre_tick;
  logic [13:0] bin_q;
  logic [13:0] mask;
  logic        t3_unf;

  assign pre_tick = (pre_q == 8'(PRE - 1));
  // steps from 8 Hz (sel 1) to 128 kHz (sel 15), sel 0 picks timer three
  assign mask     = 14'h3FFF >> (sel - 4'h1);
  assign t3_unf   = (t3_q == 16'h0000);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pre_q <= 8'h00;
    else if (pre_tick) pre_q <= 8'h00;
    else pre_q <= pre_q + 8'h01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) bin_q <= 14'h0000;
    else if (pre_tick) bin_q <= bin_q + 14'h0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) r3_q <= `ASUW_RST_T3;
    else if (r3_wr) r3_q <= wdata;
  end

  // counts down, reloads from its paired register on underflow
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) t3_q <= `ASUW_RST_T3;
    else if (t3_wr) t3_q <= wdata;
    else if (t3_unf) t3_q <= r3_q;
    else t3_q <= t3_q - 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tick <= 1'b0;
    else if (sel == 4'h0) tick <= t3_unf && !t3_wr;
    else tick <= pre_tick && ((bin_q & mask) == mask);
  end
endmodule // asuw_baud

// [asuw_rx.sv]
// receive shifter: 16x oversampled, start bit checked at mid-bit
// assumes a one-cycle tick at sixteen times the bit rate
`timescale 1ns/1ps
`include "asuw_params.svh"
module asuw_rx import asuw_pkg::*; (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // line side
  input  wire logic  tick,
  input  wire logic  rxd,
  input  wire logic  nine,
  // result
  output asuw_rx_res_t res
);
  asuw_state_t st_q;
  logic [3:0]  ovs_q;
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= ASUW_IDLE;
      ovs_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q  <= 9'h000;
      res   <= '0;
    end else begin
      res.done <= 1'b0;
      if (tick) begin
        ovs_q <= ovs_q + 4'h1;
        case (st_q)
          ASUW_IDLE: begin
            ovs_q <= 4'h0;
            if (!rxd) st_q <= ASUW_START;
          end
          ASUW_START: begin
            // a glitch shorter than half a bit is dropped here
            if (ovs_q == `ASUW_OVS_MID) begin
              ovs_q <= 4'h0;
              bit_q <= 4'h0;
              st_q  <= rxd ? ASUW_IDLE : ASUW_DATA;
            end
          end
          ASUW_DATA: begin
            if (ovs_q == `ASUW_OVS_LAST) begin
              sh_q  <= {rxd, sh_q[8:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == (nine ? 4'h8 : 4'h7)) st_q <= ASUW_STOP;
            end
          end
          ASUW_STOP: begin
            // one stop bit only, whatever the sender uses
            if (ovs_q == `ASUW_OVS_LAST) begin
              res.done <= 1'b1;
              res.ferr <= !rxd;
              res.word <= nine ? sh_q : {1'b0, sh_q[8:1]};
              st_q     <= ASUW_IDLE;
            end
          end
          default: st_q <= ASUW_IDLE;
        endcase
      end
    end
  end
endmodule // asuw_rx

// [asuw_uart.sv]
// asynchronous serial transceiver with wake-up mode, register port and rate sources
// assumes a 20 MHz clock, synchronous pins and a master that never overlaps strobes
//
// How it works
// - software picks 8 or 9 data bits in serial_ctrl_status
// - in 9-bit mode the ninth sent bit comes from a control bit
// - frame is start bit, 8 or 9 data bits, one or two stops
// - stop count for sending is chosen in irq_clock_select
// - receiver needs just one stop bit per frame
// - control register shows transmit-ready and receive-ready flags
// - framing and overrun errors are flagged in rx_ctrl_status
// - received ninth bit is kept in rx_ctrl_status
// - a bit in rx_ctrl_status turns wake-up mode on or off
// - separate transmit and receive interrupt enables in irq_clock_select
// - two bits pick internal or external rate per direction
// - internal rate is a binary step 8 Hz to 128 kHz or timer three
// - external rate comes from the external baud clock pin
// - both directions may run at different rates at once
// - ninth bit one marks an address, zero marks message data
// - in wake-up mode only address frames raise the receive interrupt
// - timer three counts down and reloads on underflow
`timescale 1ns/1ps
`include "asuw_params.svh"
module asuw_uart import asuw_pkg::*; #(
  parameter int unsigned PRE = `ASUW_PRE_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // register port
  input  wire logic [8:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // serial line
  input  wire logic        RXD,
  output logic             TXD,
  input  wire logic        EXT_BAUD_CLOCK_PIN,
  // interrupt requests
  output logic             IRQ_TX,
  output logic             IRQ_RX
);
  // register state
  logic        nine_q;
  logic        xbit9_q;
  logic        txie_q;
  logic        rxie_q;
  logic        rxext_q;
  logic        txext_q;
  logic        stop2_q;
  logic        wake_q;
  logic [3:0]  divsel_q;
  logic [7:0]  tx_buffer_q;
  logic        tx_full_q;
  asuw_word_t  rx_buffer_q;
  logic        rx_full_q;
  logic        ferr_q;
  logic        overr_q;
  logic [15:0] t3_val;
  logic [15:0] r3_val;
  // rate ticks
  logic        ext_q;
  logic        ext_tick;
  logic        int_tick;
  logic        tx_tick;
  logic        rx_tick;
  // transmitter
  asuw_state_t tx_st_q;
  logic [3:0]  tx_ovs_q;
  logic [3:0]  tx_bit_q;
  logic [8:0]  tx_sh_q;
  logic        tx_load;
  // receiver
  asuw_rx_res_t rx_res;
  logic        rx_accept;
  logic        rx_buf_rd;
  // decode strobes
  logic        wr_ctrl;
  logic        wr_irqclk;
  logic        wr_txbuf;
  logic        wr_rxctl;
  logic        wr_divsel;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction

  assign wr_ctrl   = WR && hit(ADDR, `ASUW_ADR_CTRL);
  assign wr_irqclk = WR && hit(ADDR, `ASUW_ADR_IRQCLK);
  assign wr_txbuf  = WR && hit(ADDR, `ASUW_ADR_TXBUF);
  assign wr_rxctl  = WR && hit(ADDR, `ASUW_ADR_RXCTL);
  assign wr_divsel = WR && hit(ADDR, `ASUW_ADR_DIVSEL);
  assign rx_buf_rd = RD && hit(ADDR, `ASUW_ADR_RXBUF);

  // rate sources
  asuw_baud #(
    .PRE   (PRE)
  ) u_baud (
    .clk   (CLK),
    .rstn  (RSTN),
    .sel   (divsel_q),
    .t3_wr (WR && hit(ADDR, `ASUW_ADR_T3)),
    .r3_wr (WR && hit(ADDR, `ASUW_ADR_R3)),
    .wdata (WDATA),
    .t3_q  (t3_val),
    .r3_q  (r3_val),
    .tick  (int_tick)
  );

  // the pin is sampled as a synchronous input; its rising edge is one tick
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ext_q <= 1'b0;
    else ext_q <= EXT_BAUD_CLOCK_PIN;
  end

  assign ext_tick = EXT_BAUD_CLOCK_PIN && !ext_q;
  // each direction picks its own source, so rates can differ
  assign tx_tick  = txext_q ? ext_tick : int_tick;
  assign rx_tick  = rxext_q ? ext_tick : int_tick;

  // control registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      nine_q  <= 1'b0;
      xbit9_q <= 1'b0;
    end else if (wr_ctrl) begin
      nine_q  <= WDATA[`ASUW_CTRL_NINE];
      xbit9_q <= WDATA[`ASUW_CTRL_XBIT9];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      txie_q  <= 1'b0;
      rxie_q  <= 1'b0;
      rxext_q <= 1'b0;
      txext_q <= 1'b0;
      stop2_q <= 1'b0;
    end else if (wr_irqclk) begin
      txie_q  <= WDATA[`ASUW_IC_TXIE];
      rxie_q  <= WDATA[`ASUW_IC_RXIE];
      rxext_q <= WDATA[`ASUW_IC_RXEXT];
      txext_q <= WDATA[`ASUW_IC_TXEXT];
      stop2_q <= WDATA[`ASUW_IC_STOP2];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) divsel_q <= `ASUW_RST_DIVSEL;
    else if (wr_divsel) divsel_q <= WDATA[3:0];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) wake_q <= 1'b0;
    else if (wr_rxctl) wake_q <= WDATA[`ASUW_RXC_WAKE];
  end

  // transmit buffer: a write while full overwrites the waiting byte
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) tx_buffer_q <= 8'h00;
    else if (wr_txbuf) tx_buffer_q <= WDATA[7:0];
  end

  // a write landing in the load cycle keeps the buffer full
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) tx_full_q <= 1'b0;
    else if (wr_txbuf) tx_full_q <= 1'b1;
    else if (tx_load) tx_full_q <= 1'b0;
  end

  assign tx_load = tx_full_q && (tx_st_q == ASUW_IDLE);

  // transmitter: loads on the system clock, bit timing follows the tick
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_st_q  <= ASUW_IDLE;
      tx_ovs_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 9'h1FF;
    end else begin
      case (tx_st_q)
        ASUW_IDLE: begin
          tx_ovs_q <= 4'h0;
          tx_bit_q <= 4'h0;
          if (tx_load) begin
            tx_sh_q <= {nine_q ? xbit9_q : 1'b1, tx_buffer_q};
            tx_st_q <= ASUW_START;
          end
        end
        ASUW_START: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == `ASUW_OVS_LAST) tx_st_q <= ASUW_DATA;
          end
        end
        ASUW_DATA: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == `ASUW_OVS_LAST) begin
              tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == (nine_q ? 4'h8 : 4'h7)) begin
                tx_bit_q <= 4'h0;
                tx_st_q  <= ASUW_STOP;
              end
            end
          end
        end
        ASUW_STOP: begin
          if (tx_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == `ASUW_OVS_LAST) begin
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == (stop2_q ? 4'h1 : 4'h0)) tx_st_q <= ASUW_IDLE;
            end
          end
        end
        default: tx_st_q <= ASUW_IDLE;
      endcase
    end
  end

  // line level comes from a flop so it never glitches
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) TXD <= 1'b1;
    else begin
      case (tx_st_q)
        ASUW_START: TXD <= 1'b0;
        ASUW_DATA:  TXD <= tx_sh_q[0];
        default:    TXD <= 1'b1;
      endcase
    end
  end

  // receiver
  asuw_rx u_rx (
    .clk   (CLK),
    .rstn  (RSTN),
    .tick  (rx_tick),
    .rxd   (RXD),
    .nine  (nine_q),
    .res   (rx_res)
  );

  // in wake-up mode message data is dropped until software acts on an address
  assign rx_accept = rx_res.done && (!wake_q || rx_res.word.nine);

  // a read in the same cycle as a new frame frees the buffer for it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) rx_buffer_q <= '0;
    else if (rx_accept && (!rx_full_q || rx_buf_rd)) rx_buffer_q <= rx_res.word;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) rx_full_q <= 1'b0;
    else if (rx_accept) rx_full_q <= 1'b1;
    else if (rx_buf_rd) rx_full_q <= 1'b0;
  end

  // error flags: write one to clear, a new event wins over the clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) overr_q <= 1'b0;
    else if (rx_accept && rx_full_q && !rx_buf_rd) overr_q <= 1'b1;
    else if (wr_rxctl && WDATA[`ASUW_RXC_OVERR]) overr_q <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ferr_q <= 1'b0;
    else if (rx_accept && rx_res.ferr) ferr_q <= 1'b1;
    else if (wr_rxctl && WDATA[`ASUW_RXC_FERR]) ferr_q <= 1'b0;
  end

  // interrupt requests are levels that follow the flags
  assign IRQ_TX = txie_q && !tx_full_q;
  assign IRQ_RX = rxie_q && rx_full_q;

  // read data stand in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) RDATA <= 16'h0000;
    else if (RD) begin
      case (ADDR)
        `ASUW_ADR_CTRL:   RDATA <= {12'h000, nine_q, xbit9_q, rx_full_q, !tx_full_q};
        `ASUW_ADR_IRQCLK: RDATA <= {11'h000, stop2_q, txext_q, rxext_q, rxie_q, txie_q};
        `ASUW_ADR_RXBUF:  RDATA <= {8'h00, rx_buffer_q.data};
        `ASUW_ADR_TXBUF:  RDATA <= {8'h00, tx_buffer_q};
        `ASUW_ADR_RXCTL:  RDATA <= {12'h000, overr_q, ferr_q, wake_q, rx_buffer_q.nine};
        `ASUW_ADR_R3:     RDATA <= r3_val;
        `ASUW_ADR_T3:     RDATA <= t3_val;
        `ASUW_ADR_DIVSEL: RDATA <= {12'h000, divsel_q};
        default:          RDATA <= 16'h0000;
      endcase
    end else RDATA <= 16'h0000;
  end
endmodule // asuw_uart

// [asuw_node.sv]
// remote serial node: drives the receive line and listens on the transmit line
// assumes the bench clock; bit cell length is given in clock cycles per call
`timescale 1ns/1ps
module asuw_node import asuw_pkg::*; (
  // clock
  input  wire logic clk,
  // serial line
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  // ninth bit one marks an address word, zero a data word
  task automatic send(input logic [8:0] w, input int nb, input logic sv, input int cyc);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (cyc) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= w[i];
      repeat (cyc) @(posedge clk);
    end
    rxd <= sv;
    // a bad stop is held just past mid-cell so no false start follows
    repeat (sv ? cyc : cyc / 2 + 2) @(posedge clk);
    rxd <= 1'b1;
  endtask
  task automatic capture(output logic [8:0] w, output logic ok, input int nb, input int ns,
                         input int cyc);
    int n;
    w = '0;
    ok = 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n < 4000) begin
      repeat (cyc / 2) @(posedge clk);
      ok = (txd === 1'b0);
      for (int i = 0; i < nb; i++) begin
        repeat (cyc) @(posedge clk);
        w[i] = txd;
      end
      repeat (ns) begin
        repeat (cyc) @(posedge clk);
        ok = ok & (txd === 1'b1);
      end
    end
  endtask
endmodule // asuw_node

// [asuw_uart_assertions.sv]
// port checker of the serial transceiver, bound to its top module
// assumes one clock, async active-low reset and the register map of the params header
`timescale 1ns/1ps
`include "asuw_params.svh"
module asuw_uart_chk import asuw_pkg::*; #(
  parameter int unsigned PRE = 2
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // register port
  input wire logic [8:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  // line and requests
  input wire logic        TXD,
  input wire logic        IRQ_TX,
  input wire logic        IRQ_RX
);
  logic [1:0] ie_q;
  logic [1:0] cb_q;
  logic       map_hit;
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  assign map_hit = ADDR inside {`ASUW_ADR_CTRL, `ASUW_ADR_IRQCLK, `ASUW_ADR_RXBUF,
    `ASUW_ADR_TXBUF, `ASUW_ADR_RXCTL, `ASUW_ADR_R3, `ASUW_ADR_T3, `ASUW_ADR_DIVSEL};
  // shadows rebuilt from port writes, so no design internals are needed
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ie_q <= 2'h0;
    else if (WR && ADDR == `ASUW_ADR_IRQCLK) ie_q <= WDATA[1:0];
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) cb_q <= 2'h0;
    else if (WR && ADDR == `ASUW_ADR_CTRL) cb_q <= WDATA[3:2];
  end
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property ($past(RD) && !$past(map_hit) |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_txie_gate: assert property (!ie_q[0] |-> !IRQ_TX)
    else $error("tx request while disabled");
  a_rxie_gate: assert property (!ie_q[1] |-> !IRQ_RX)
    else $error("rx request while disabled");
  a_ctrl_bits: assert property ($past(RD && ADDR == `ASUW_ADR_CTRL)
    |-> RDATA[15:2] == {12'h000, $past(cb_q)})
    else $error("frame control bits wrong");
  a_txrdy_flag: assert property ($past(RD && ADDR == `ASUW_ADR_CTRL && ie_q[0])
    |-> RDATA[0] == $past(IRQ_TX))
    else $error("tx ready flag disagrees");
  a_rxrdy_flag: assert property ($past(RD && ADDR == `ASUW_ADR_CTRL && ie_q[1])
    |-> RDATA[1] == $past(IRQ_RX))
    else $error("rx ready flag disagrees");
  a_rx_clear: assert property ($past(RD && ADDR == `ASUW_ADR_RXBUF && ie_q[1]) |-> !IRQ_RX)
    else $error("buffer read left rx ready");
  a_low_hold: assert property ($fell(TXD) |-> !TXD [*8])
    else $error("low cell too short");
  a_high_hold: assert property ($rose(TXD) |-> TXD [*8])
    else $error("high cell too short");
  a_reset_idle: assert property ($rose(RSTN) |-> TXD && !IRQ_TX && !IRQ_RX)
    else $error("not idle after reset");
  c_tx_frame: cover property ($fell(TXD));
  c_rx_irq: cover property ($rose(IRQ_RX));
  c_tx_irq: cover property ($rose(IRQ_TX));
endmodule // asuw_uart_chk
bind asuw_uart asuw_uart_chk #(.PRE(PRE)) chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD(TXD), .IRQ_TX(IRQ_TX), .IRQ_RX(IRQ_RX));

// [asuw_uart_bench.sv]
// self-checking bench of the serial transceiver with a remote node on the line
// assumes PRE of 2, so a sel 15 bit cell is 32 clocks and an external cell 64
`timescale 1ns/1ps
`include "asuw_params.svh"
module asuw_uart_bench import asuw_pkg::*;;
  logic        clk, rstn, wr, rd, txd, rxd, irq_tx, irq_rx, ok;
  logic [1:0]  ext_cnt;
  logic [8:0]  addr, w;
  logic [15:0] wdata, rdata;
  int          err_total, tests_run;
  asuw_uart #(.PRE(2)) uut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RXD(rxd), .TXD(txd), .EXT_BAUD_CLOCK_PIN(ext_cnt[1]),
    .IRQ_TX(irq_tx), .IRQ_RX(irq_rx));
  asuw_node node (.clk(clk), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // external rate runs free: one tick every four clocks
  always @(posedge clk) ext_cnt <= ext_cnt + 2'h1;
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [8:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(nm, exp, rdata);
  endtask
  task automatic frame(input logic [8:0] exp, input int nb, input int ns, input int cyc);
    node.capture(w, ok, nb, ns, cyc);
    check("frame", {7'h0, exp}, {7'h0, w});
    check("cells", 16'h0001, {15'h0, ok});
  endtask
  task automatic t_reset;
    rreg(`ASUW_ADR_CTRL, 16'h0001, "ctrl");
    rreg(`ASUW_ADR_IRQCLK, 16'h0000, "irqclk");
    rreg(`ASUW_ADR_DIVSEL, 16'h000F, "divsel");
    rreg(`ASUW_ADR_R3, 16'hFFFF, "reload");
    rreg(`ASUW_ADR_RXCTL, 16'h0000, "rxctl");
    rreg(9'h100, 16'h0000, "unmapped");
  endtask
  task automatic t_tx8;
    wreg(`ASUW_ADR_IRQCLK, 16'h0001);
    @(negedge clk);
    check("irq_tx", 16'h0001, {15'h0, irq_tx});
    wreg(`ASUW_ADR_TXBUF, 16'h00A5);
    wreg(`ASUW_ADR_TXBUF, 16'h003C);
    rreg(`ASUW_ADR_CTRL, 16'h0000, "ctrl");
    frame(9'h0A5, 8, 1, 32);
    frame(9'h03C, 8, 1, 32);
    rreg(`ASUW_ADR_CTRL, 16'h0001, "ctrl");
  endtask
  task automatic t_tx9;
    wreg(`ASUW_ADR_R3, 16'h0001);
    wreg(`ASUW_ADR_T3, 16'h0001);
    wreg(`ASUW_ADR_DIVSEL, 16'h0000);
    rreg(`ASUW_ADR_R3, 16'h0001, "reload");
    wreg(`ASUW_ADR_CTRL, 16'h000C);
    wreg(`ASUW_ADR_IRQCLK, 16'h0010);
    wreg(`ASUW_ADR_TXBUF, 16'h005A);
    wreg(`ASUW_ADR_TXBUF, 16'h00A5);
    frame(9'h15A, 9, 2, 32);
    frame(9'h1A5, 9, 1, 32);
    wreg(`ASUW_ADR_DIVSEL, 16'h000F);
    wreg(`ASUW_ADR_CTRL, 16'h0000);
  endtask
  task automatic t_rx;
    wreg(`ASUW_ADR_IRQCLK, 16'h0012);
    node.send(9'h096, 8, 1'b1, 32);
    @(negedge clk);
    check("irq_rx", 16'h0001, {15'h0, irq_rx});
    rreg(`ASUW_ADR_CTRL, 16'h0003, "ctrl");
    rreg(`ASUW_ADR_RXBUF, 16'h0096, "rxbuf");
    node.send(9'h011, 8, 1'b1, 32);
    node.send(9'h022, 8, 1'b1, 32);
    rreg(`ASUW_ADR_RXCTL, 16'h0008, "rxctl");
    rreg(`ASUW_ADR_RXBUF, 16'h0011, "rxbuf");
    wreg(`ASUW_ADR_RXCTL, 16'h0008);
    node.send(9'h033, 8, 1'b0, 32);
    rreg(`ASUW_ADR_RXCTL, 16'h0004, "rxctl");
    rreg(`ASUW_ADR_RXBUF, 16'h0033, "rxbuf");
  endtask
  task automatic t_wake;
    wreg(`ASUW_ADR_CTRL, 16'h0008);
    wreg(`ASUW_ADR_RXCTL, 16'h0006);
    wreg(`ASUW_ADR_IRQCLK, 16'h0006);
    fork
      begin
        node.send(9'h044, 9, 1'b1, 64);
        @(negedge clk);
        check("irq_rx", 16'h0000, {15'h0, irq_rx});
        node.send(9'h1C3, 9, 1'b1, 64);
      end
      begin
        wreg(`ASUW_ADR_TXBUF, 16'h0081);
        frame(9'h081, 9, 1, 32);
      end
    join
    @(negedge clk);
    check("irq_rx", 16'h0001, {15'h0, irq_rx});
    rreg(`ASUW_ADR_RXCTL, 16'h0003, "rxctl");
    rreg(`ASUW_ADR_RXBUF, 16'h00C3, "rxbuf");
  endtask
  task automatic t_txext;
    wreg(`ASUW_ADR_CTRL, 16'h0000);
    wreg(`ASUW_ADR_IRQCLK, 16'h0008);
    wreg(`ASUW_ADR_TXBUF, 16'h00C6);
    frame(9'h0C6, 8, 1, 64);
    rreg(`ASUW_ADR_IRQCLK, 16'h0008, "irqclk");
  endtask
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    ext_cnt = '0;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_tx8;
    t_tx9;
    t_rx;
    t_wake;
    t_txext;
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test;
  end
endmodule // asuw_uart_bench
